//--- design/ppc_map.vh
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
// register addresses
`define PPC_ADDR_DETECT_CTRL 8'h9a
`define PPC_ADDR_STATUS 8'h9b
`define PPC_ADDR_THRESHOLD 8'h9c
`define PPC_ADDR_INT_ENABLE 8'h9d
`define PPC_ADDR_CLK_MASK 8'ha1
`define PPC_ADDR_PIN_FUNC 8'ha6
`define PPC_ADDR_PWM0_CTRL 8'ha7
// status fields
`define PPC_ST_CMP4 6
`define PPC_ST_CMP2 5
`define PPC_ST_CMP1 4
`define PPC_ST_PROT_IF 3
`define PPC_ST_OFF 2
`define PPC_ST_NO_PHASE 1
`define PPC_ST_SMALL 0
// protection enable fields
`define PPC_IE_CMP4_OFF 5
`define PPC_IE_CMP2_OFF 4
`define PPC_IE_CMP1_OFF 3
`define PPC_IE_PD_OFF 2
`define PPC_IE_OFF_INT 1
`define PPC_IE_PROT_INT 0
// clock and mask fields
`define PPC_CK_PWM1_HI 7
`define PPC_CK_PWM1_LO 6
`define PPC_CK_PWM0_HI 3
`define PPC_CK_PWM0_LO 2
`define PPC_CK_NMASK 1
`define PPC_CK_PMASK 0
// pin function fields
`define PPC_PF_PWM1 7
`define PPC_PF_POS 6
`define PPC_PF_NEG 5
// pwm0 control fields
`define PPC_P0_MASK_EN 6
// detect control fields
`define PPC_DC_DELAY_HI 6
`define PPC_DC_DELAY_LO 4
`define PPC_DC_ENABLE 0
// clock select codes
`define PPC_CKS_SYS0 2'h0
`define PPC_CKS_SYS1 2'h1
`define PPC_CKS_RC 2'h2
`define PPC_CKS_RC2X 2'h3
// reset values
`define PPC_RST_BYTE 8'h00
`endif

//--- design/ppc_sync_edge.v
`timescale 1ns/1ns
`default_nettype none
module ppc_sync_edge #(
  parameter W = 4
) (
  input wire ref_clk,
  input wire resetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] level_reg,
  output reg [W-1:0] edge_reg
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge ref_clk)
      begin
        if (!resetn)
        begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
          level_reg[i] <= 1'b0;
          edge_reg[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
          level_reg[i] <= sync_reg[i];
          // either direction counts as an event
          edge_reg[i] <= sync_reg[i] ^ level_reg[i];
        end
      end
    end
  endgenerate
endmodule // ppc_sync_edge
`default_nettype wire

//--- design/ppc_phase_meter.v
`timescale 1ns/1ns
`default_nettype none
module ppc_phase_meter #(
  parameter CW = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire active,
  input wire period_tick,
  input wire phase_level,
  input wire [CW-1:0] threshold,
  output reg no_phase_reg,
  output reg small_phase_reg
);
  reg [CW-1:0] width_reg;
  reg seen_reg;
  reg prev_reg;
  wire fall = prev_reg & ~phase_level;
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      width_reg <= {CW{1'b0}};
      seen_reg <= 1'b0;
      prev_reg <= 1'b0;
      no_phase_reg <= 1'b0;
      small_phase_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= phase_level;
      no_phase_reg <= 1'b0;
      small_phase_reg <= 1'b0;
      if (!active)
      begin
        width_reg <= {CW{1'b0}};
        seen_reg <= 1'b0;
      end
      else
      begin
        // saturate so a stuck-high phase never wraps into a small width
        if (phase_level && width_reg != {CW{1'b1}})
          width_reg <= width_reg + {{(CW-1){1'b0}}, 1'b1};
        if (fall)
        begin
          seen_reg <= 1'b1;
          width_reg <= {CW{1'b0}};
          small_phase_reg <= (width_reg < threshold); // R6
        end
        if (period_tick)
        begin
          no_phase_reg <= ~(seen_reg | fall | phase_level); // R5
          seen_reg <= 1'b0;
        end
      end
    end
  end
endmodule // ppc_phase_meter
`default_nettype wire

//--- design/ppc_protect_ctrl.v
// Behaviour
// R1: comparator 2 either edge sets status bit 5; writing 0 there clears it.
// R2: comparator 1 either edge sets status bit 4; writing 0 there clears it.
// R3: bit 3 sets while no-phase or small-phase flag is 1; cleared by write.
// R4: bit 2 sets when protection forces PWM0 off; cleared by write.
// R5: bit 1 sets when no phase width is detected; cleared by write.
// R6: bit 0 sets when phase width below threshold; cleared by write.
// R7: eight-bit read/write phase width threshold, reset zero.
// R8: enable bits 5,4,3 let comparators 4,2,1 force PWM0 off.
// R9: enable bit 2 lets phase detector conditions force PWM0 off.
// R10: enable bit 1 gates forced-off flag onto interrupt request.
// R11: enable bit 0 gates protection flag onto interrupt request.
// R12: clock select 00/01 system, 10 RC oscillator, 11 doubled RC.
// R13: while cleared or forced off, negative output drives mask bit 1.
// R14: while cleared or forced off, positive output drives mask bit 0.
// R15: pin bits 7,6,5 route PWM1, positive, negative PWM0 to pins.
// R16: PWM0 control bit 6 enables output mask, reset zero.
// R17: comparator 4 either edge sets status bit 6; writing 0 clears it.
// R18: after clear returns low, detection waits 0 to 7 PWM periods.
// R19: status write clears only zero bits; hardware set wins over clear.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_map.vh"
module ppc_protect_ctrl #(
  parameter TW = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire cmp1_out,
  input wire cmp2_out,
  input wire cmp4_out,
  input wire phase_in,
  input wire pwm0_clear_control,
  input wire pwm_period_tick,
  input wire pwm0_p_raw,
  input wire pwm0_n_raw,
  input wire pwm1_raw,
  input wire port_p33_out,
  input wire port_p35_out,
  input wire port_p12_out,
  output reg pin_p33_out,
  output reg pin_p35_out,
  output reg pin_p12_out,
  output reg pwm0_p_out,
  output reg pwm0_n_out,
  output reg pwm0_forced_off,
  output reg protection_int_req,
  output reg [1:0] pwm0_clock_select,
  output reg [1:0] pwm1_clock_select
);
  reg [7:0] detect_ctrl_reg;
  reg [6:0] status_reg;
  reg [6:0] status_next;
  reg [TW-1:0] phase_width_threshold_reg;
  reg [5:0] protection_int_enable_reg;
  reg [7:0] pwm_clock_and_mask_reg;
  reg [2:0] pin_function_select_reg;
  reg output_mask_enable_reg;
  reg [2:0] wait_cnt_reg;
  reg wait_done_reg;
  reg clear_prev_reg;
  wire [3:0] sync_level;
  wire [3:0] sync_edge;
  wire no_phase_evt;
  wire small_phase_evt;
  wire wr_status = sfr_wr && (sfr_addr == `PPC_ADDR_STATUS);
  wire [2:0] start_delay = detect_ctrl_reg[`PPC_DC_DELAY_HI:`PPC_DC_DELAY_LO];
  wire detect_active = detect_ctrl_reg[`PPC_DC_ENABLE] & ~pwm0_clear_control & wait_done_reg;
  wire phase_fault = no_phase_evt | small_phase_evt;
  wire shutdown_evt =
    (protection_int_enable_reg[`PPC_IE_CMP4_OFF] & sync_edge[2]) | // R8
    (protection_int_enable_reg[`PPC_IE_CMP2_OFF] & sync_edge[1]) | // R8
    (protection_int_enable_reg[`PPC_IE_CMP1_OFF] & sync_edge[0]) | // R8
    (protection_int_enable_reg[`PPC_IE_PD_OFF] & phase_fault); // R9
  wire masked = pwm0_clear_control | status_reg[`PPC_ST_OFF];
  // bit order: 0 cmp1, 1 cmp2, 2 cmp4, 3 phase
  ppc_sync_edge #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({phase_in, cmp4_out, cmp2_out, cmp1_out}),
    .level_reg(sync_level),
    .edge_reg(sync_edge)
  );
  ppc_phase_meter #(
    .CW(TW)
  ) u_meter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .active(detect_active),
    .period_tick(pwm_period_tick),
    .phase_level(sync_level[3]),
    .threshold(phase_width_threshold_reg),
    .no_phase_reg(no_phase_evt),
    .small_phase_reg(small_phase_evt)
  );
  // start-of-detection delay counted in pwm periods
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wait_cnt_reg <= 3'h0;
      wait_done_reg <= 1'b0;
      clear_prev_reg <= 1'b0;
    end
    else
    begin
      clear_prev_reg <= pwm0_clear_control;
      if (pwm0_clear_control)
      begin
        wait_cnt_reg <= 3'h0;
        wait_done_reg <= 1'b0;
      end
      else if (clear_prev_reg || !wait_done_reg)
      begin
        if (wait_cnt_reg >= start_delay) // R18
          wait_done_reg <= 1'b1;
        else if (pwm_period_tick)
          wait_cnt_reg <= wait_cnt_reg + 3'h1; // R18
      end
    end
  end
  always @*
  begin
    status_next = status_reg;
    if (wr_status)
      status_next = status_reg & sfr_wdata[6:0]; // R19
    if (sync_edge[2])
      status_next[`PPC_ST_CMP4] = 1'b1; // R17
    if (sync_edge[1])
      status_next[`PPC_ST_CMP2] = 1'b1; // R1
    if (sync_edge[0])
      status_next[`PPC_ST_CMP1] = 1'b1; // R2
    if (status_reg[`PPC_ST_NO_PHASE] | status_reg[`PPC_ST_SMALL])
      status_next[`PPC_ST_PROT_IF] = 1'b1; // R3
    if (shutdown_evt)
      status_next[`PPC_ST_OFF] = 1'b1; // R4
    if (no_phase_evt)
      status_next[`PPC_ST_NO_PHASE] = 1'b1; // R5
    if (small_phase_evt)
      status_next[`PPC_ST_SMALL] = 1'b1; // R6
  end
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      status_reg <= 7'h00;
      detect_ctrl_reg <= `PPC_RST_BYTE;
      phase_width_threshold_reg <= {TW{1'b0}}; // R7
      protection_int_enable_reg <= 6'h00; // R8
      pwm_clock_and_mask_reg <= `PPC_RST_BYTE;
      pin_function_select_reg <= 3'h0;
      output_mask_enable_reg <= 1'b0; // R16
    end
    else
    begin
      status_reg <= status_next;
      if (sfr_wr)
      begin
        case (sfr_addr)
          `PPC_ADDR_DETECT_CTRL: detect_ctrl_reg <= sfr_wdata & 8'h71;
          `PPC_ADDR_THRESHOLD: phase_width_threshold_reg <= sfr_wdata[TW-1:0]; // R7
          `PPC_ADDR_INT_ENABLE: protection_int_enable_reg <= sfr_wdata[5:0];
          `PPC_ADDR_CLK_MASK: pwm_clock_and_mask_reg <= sfr_wdata & 8'hcf;
          `PPC_ADDR_PIN_FUNC: pin_function_select_reg <= sfr_wdata[7:5];
          `PPC_ADDR_PWM0_CTRL: output_mask_enable_reg <= sfr_wdata[`PPC_P0_MASK_EN]; // R16
          default: ;
        endcase
      end
    end
  end
  always @(posedge ref_clk)
  begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `PPC_ADDR_DETECT_CTRL: sfr_rdata <= detect_ctrl_reg;
        `PPC_ADDR_STATUS: sfr_rdata <= {1'b0, status_reg};
        `PPC_ADDR_THRESHOLD: sfr_rdata <= phase_width_threshold_reg;
        `PPC_ADDR_INT_ENABLE: sfr_rdata <= {2'h0, protection_int_enable_reg};
        `PPC_ADDR_CLK_MASK: sfr_rdata <= pwm_clock_and_mask_reg;
        `PPC_ADDR_PIN_FUNC: sfr_rdata <= {pin_function_select_reg, 5'h00};
        `PPC_ADDR_PWM0_CTRL: sfr_rdata <= {1'b0, output_mask_enable_reg, 6'h00};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end
  // outputs, all registered
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pwm0_p_out <= 1'b0;
      pwm0_n_out <= 1'b0;
      pin_p33_out <= 1'b0;
      pin_p35_out <= 1'b0;
      pin_p12_out <= 1'b0;
      pwm0_forced_off <= 1'b0;
      protection_int_req <= 1'b0;
      pwm0_clock_select <= `PPC_CKS_SYS0;
      pwm1_clock_select <= `PPC_CKS_SYS0;
    end
    else
    begin
      pwm0_forced_off <= masked;
      // mask off: outputs fall to 0 rather than mask levels when held
      pwm0_n_out <= masked ? (output_mask_enable_reg &
        pwm_clock_and_mask_reg[`PPC_CK_NMASK]) : pwm0_n_raw; // R13
      pwm0_p_out <= masked ? (output_mask_enable_reg &
        pwm_clock_and_mask_reg[`PPC_CK_PMASK]) : pwm0_p_raw; // R14
      pin_p33_out <= pin_function_select_reg[2] ? pwm1_raw : port_p33_out; // R15
      pin_p35_out <= pin_function_select_reg[1] ?
        (masked ? (output_mask_enable_reg & pwm_clock_and_mask_reg[`PPC_CK_PMASK])
        : pwm0_p_raw) : port_p35_out; // R15
      pin_p12_out <= pin_function_select_reg[0] ?
        (masked ? (output_mask_enable_reg & pwm_clock_and_mask_reg[`PPC_CK_NMASK])
        : pwm0_n_raw) : port_p12_out; // R15
      protection_int_req <=
        (protection_int_enable_reg[`PPC_IE_OFF_INT] & status_reg[`PPC_ST_OFF]) | // R10
        (protection_int_enable_reg[`PPC_IE_PROT_INT] & status_reg[`PPC_ST_PROT_IF]); // R11
      // codes 00/01 both select system clock
      pwm0_clock_select <= pwm_clock_and_mask_reg[`PPC_CK_PWM0_HI:`PPC_CK_PWM0_LO]; // R12
      pwm1_clock_select <= pwm_clock_and_mask_reg[`PPC_CK_PWM1_HI:`PPC_CK_PWM1_LO]; // R12
    end
  end
endmodule // ppc_protect_ctrl
`default_nettype wire

//--- test/ppc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// comparator and phase detector outputs, settling a little after the request
module ppc_analog_model (
  input wire logic [3:0] want,
  output wire logic [3:0] lvl
);
  // continuous so the levels follow want 3 ns later; they are unknown for the first 3 ns
  assign #3 lvl = want;
endmodule // ppc_analog_model
`default_nettype wire

//--- test/ppc_protect_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_protect_ctrl_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic pwm0_clear_control,
  input wire logic pwm0_p_raw,
  input wire logic pwm0_n_raw,
  input wire logic port_p33_out,
  input wire logic port_p12_out,
  input wire logic pin_p33_out,
  input wire logic pin_p12_out,
  input wire logic pwm0_p_out,
  input wire logic pwm0_n_out,
  input wire logic pwm0_forced_off,
  input wire logic protection_int_req,
  input wire logic [1:0] pwm0_clock_select,
  input wire logic [1:0] pwm1_clock_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // set by the first write to routing or enables; before it both stay at reset
  logic cfg_w_reg;
  always @(posedge ref_clk)
    cfg_w_reg <= resetn & (cfg_w_reg | (sfr_wr & (sfr_addr == 8'ha6 | sfr_addr == 8'h9d)));
  clear_forces_a: assert property (pwm0_clear_control |=> pwm0_forced_off)
    else $error("clear control did not force pwm0 off");
  pass_thru_a: assert property (!pwm0_forced_off |-> pwm0_p_out == $past(pwm0_p_raw)
    && pwm0_n_out == $past(pwm0_n_raw)) else $error("pwm0 outputs not following raw");
  ck0_change_a: assert property ($changed(pwm0_clock_select) |->
    $past(sfr_wr && sfr_addr == 8'ha1) || $past(sfr_wr && sfr_addr == 8'ha1, 2))
    else $error("pwm0 clock select changed without write");
  ck1_change_a: assert property ($changed(pwm1_clock_select) |->
    $past(sfr_wr && sfr_addr == 8'ha1) || $past(sfr_wr && sfr_addr == 8'ha1, 2))
    else $error("pwm1 clock select changed without write");
  rdata_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved without read");
  off_holds_a: assert property (pwm0_forced_off && !$past(pwm0_clear_control)
    && !$past(sfr_wr) |=> pwm0_forced_off) else $error("forced off dropped without clear");
  pins_idle_a: assert property (!cfg_w_reg |-> pin_p33_out == $past(port_p33_out)
    && pin_p12_out == $past(port_p12_out)) else $error("pin left port function");
  irq_idle_a: assert property (!cfg_w_reg |-> !protection_int_req)
    else $error("interrupt with enables at reset");
endmodule // ppc_protect_ctrl_chk
bind ppc_protect_ctrl ppc_protect_ctrl_chk ppc_protect_ctrl_chk_inst (.ref_clk, .resetn,
  .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rdata, .pwm0_clear_control, .pwm0_p_raw, .pwm0_n_raw,
  .port_p33_out, .port_p12_out, .pin_p33_out, .pin_p12_out, .pwm0_p_out, .pwm0_n_out,
  .pwm0_forced_off, .protection_int_req, .pwm0_clock_select, .pwm1_clock_select);
`default_nettype wire

//--- test/ppc_protect_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_protect_ctrl_bench;
  logic ref_clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, clr = 0, tick = 0;
  logic p_raw = 0, n_raw = 0, w1_raw = 0, pin33, pin35, pin12, p_out, n_out, fo, irq;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [3:0] want = 4'h0;
  wire logic [3:0] lvl;
  logic [2:0] port = 3'h0;
  logic [1:0] ck0, ck1;
  logic [7:0] ev [0:2] = '{8'h10, 8'h20, 8'h40};
  logic [7:0] en [0:2] = '{8'h0a, 8'h12, 8'h22};
  logic [7:0] cl [0:2] = '{8'hef, 8'hdf, 8'hbf};
  int failures = 0, comparisons = 0;
  always #2 ref_clk = ~ref_clk;
  ppc_analog_model ppc_analog_model_inst (.want(want), .lvl(lvl));
  ppc_protect_ctrl ppc_protect_ctrl_inst (.ref_clk(ref_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .cmp1_out(lvl[0]), .cmp2_out(lvl[1]), .cmp4_out(lvl[2]),
    .phase_in(lvl[3]), .pwm0_clear_control(clr), .pwm_period_tick(tick),
    .pwm0_p_raw(p_raw), .pwm0_n_raw(n_raw), .pwm1_raw(w1_raw), .port_p33_out(port[2]),
    .port_p35_out(port[1]), .port_p12_out(port[0]), .pin_p33_out(pin33),
    .pin_p35_out(pin35), .pin_p12_out(pin12), .pwm0_p_out(p_out), .pwm0_n_out(n_out),
    .pwm0_forced_off(fo), .protection_int_req(irq), .pwm0_clock_select(ck0),
    .pwm1_clock_select(ck1));
  task report_and_stop;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 chk(nm, e, sfr_rdata);
  endtask
  task wfo(input logic v);
    for (int i = 0; i < 40 && fo !== v; i++)
      @(posedge ref_clk) #1;
    chk("forced_off", {7'h0, v}, {7'h0, fo});
    if (fo !== v)
      report_and_stop;
  endtask
  task t_regs;
    rchk("threshold", 8'h9c, 8'h00);
    rchk("int_enable", 8'h9d, 8'h00);
    rchk("pwm0_ctrl", 8'ha7, 8'h00);
    wr(8'h9c, 8'ha5);
    rchk("threshold", 8'h9c, 8'ha5);
    wr(8'h9c, 8'h00);
  endtask
  task t_clk;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'ha1, {c[1:0], 2'h0, c[1:0], 2'h0});
      repeat (2) @(posedge ref_clk);
      #1 chk("clock_select", {4'h0, c[1:0], c[1:0]}, {4'h0, ck1, ck0});
    end
  endtask
  task t_pins;
    @(posedge ref_clk);
    port <= 3'h5;
    w1_raw <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("pins_port", 8'h05, {5'h0, pin33, pin35, pin12});
    wr(8'ha6, 8'he0);
    repeat (3) @(posedge ref_clk);
    #1 chk("pins_pwm", 8'h04, {5'h0, pin33, pin35, pin12});
    wr(8'ha6, 8'h00);
  endtask
  task t_mask;
    wr(8'ha7, 8'h40);
    wr(8'ha1, 8'h02);
    @(posedge ref_clk);
    p_raw <= 1'b1;
    clr <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("masked", 8'h05, {5'h0, fo, p_out, n_out});
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("unmasked", 8'h02, {5'h0, fo, p_out, n_out});
  endtask
  task t_cmp;
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h9d, 8'h00);
      @(posedge ref_clk);
      want[i] <= ~want[i];
      repeat (10) @(posedge ref_clk);
      rchk("status_evt", 8'h9b, ev[i]);
      wr(8'h9d, en[i]);
      @(posedge ref_clk);
      want[i] <= ~want[i];
      wfo(1'b1);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", 8'h01, {7'h0, irq});
      wr(8'h9b, cl[i]);
      rchk("status_clr", 8'h9b, 8'h04);
      wr(8'h9b, 8'hfb);
      wfo(1'b0);
    end
  endtask
  task t_phase;
    wr(8'h9d, 8'h04);
    wr(8'h9a, 8'h01);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (3)
    begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    rchk("no_phase", 8'h9b, 8'h0e);
    wr(8'h9c, 8'h40);
    wr(8'h9b, 8'h00);
    @(posedge ref_clk);
    want[3] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    want[3] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rchk("small_phase", 8'h9b, 8'h0d);
  endtask
  task t_gate;
    #1 chk("irq_gated", 8'h00, {7'h0, irq});
    wr(8'h9d, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_prot", 8'h01, {7'h0, irq});
    wr(8'ha7, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("mask_off", 8'h00, {7'h0, n_out});
    wr(8'h9a, 8'h21);
    // first write lets bit 3 re-set from the old phase flags
    wr(8'h9b, 8'h00);
    wr(8'h9b, 8'h00);
    rchk("cleared", 8'h9b, 8'h00);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (2)
    begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    rchk("delay_wait", 8'h9b, 8'h00);
    @(posedge ref_clk);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rchk("delay_done", 8'h9b, 8'h0a);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs;
    t_clk;
    t_pins;
    t_mask;
    t_cmp;
    t_phase;
    t_gate;
    report_and_stop;
  end
endmodule // ppc_protect_ctrl_bench
`default_nettype wire
